// [src/dmx_defines.vh]
// Shared encodings and field positions for the data-move execution block
`ifndef DMX_DEFINES_VH
`define DMX_DEFINES_VH

// ****************************************
// Instruction fields
// ****************************************
`define DMX_NIB_HI          15
`define DMX_NIB_LO          12
`define DMX_BYTE_HI         15
`define DMX_BYTE_LO         8
`define DMX_ADDR_HI         11
`define DMX_LIT_HI          7
`define DMX_OP7_HI          15
`define DMX_OP7_LO          9
`define DMX_ABIT            8
`define DMX_BANK_HI         3

// ****************************************
// Opcodes
// ****************************************
`define DMX_OP_MOVE_FIRST   4'hc
`define DMX_OP_MOVE_SECOND  4'hf
`define DMX_OP_LOAD_BANK    8'h01
`define DMX_OP_LOAD_WORK    8'h0e
`define DMX_OP_STORE_WORK   7'h37

// ****************************************
// Quarter sequencing and reset values
// ****************************************
`define DMX_QCNT_W          2
`define DMX_Q1              2'h0
`define DMX_Q2              2'h1
`define DMX_Q3              2'h2
`define DMX_Q4              2'h3
`define DMX_BYTE_RST        8'h00
`define DMX_ADDR_RST        12'h000
`define DMX_WORK_ADDR       12'hff0
`define DMX_ACCESS_SPLIT    8'h80
`define DMX_ACCESS_HI_BANK  4'hf
`define DMX_ACCESS_LO_BANK  4'h0

`endif

// [src/dmx_quarter.v]
// Quarter-cycle generator: four one-cycle phase enables per instruction cycle
`timescale 1ns/1ps
`default_nettype none
`include "dmx_defines.vh"

module dmx_quarter
(
    input  wire         i_ref_clk,
    input  wire         i_reset,
    output wire         o_q1,
    output wire         o_q2,
    output wire         o_q3,
    output wire         o_q4
);

    reg  [`DMX_QCNT_W-1:0] qcnt_r;

    always @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
            qcnt_r <= `DMX_Q1;
        else
            qcnt_r <= qcnt_r + {{(`DMX_QCNT_W-1){1'b0}}, 1'b1};
    end

    assign o_q1 = (qcnt_r == `DMX_Q1);
    assign o_q2 = (qcnt_r == `DMX_Q2);
    assign o_q3 = (qcnt_r == `DMX_Q3);
    assign o_q4 = (qcnt_r == `DMX_Q4);

endmodule

`default_nettype wire

// [src/dmx_exec.v]
// Decode and execute logic for the four data-move instructions
`timescale 1ns/1ps
`default_nettype none
`include "dmx_defines.vh"

module dmx_exec
#(
    parameter [11:0] WORK_ADDR    = `DMX_WORK_ADDR,
    parameter [7:0]  ACCESS_SPLIT = `DMX_ACCESS_SPLIT
)
(
    input  wire         i_ref_clk,
    input  wire         i_reset,
    input  wire [15:0]  i_instr,
    input  wire         i_hold,
    input  wire [7:0]   i_mem_rdata,
    output wire         o_word_taken,
    output wire         o_done,
    output wire         o_not_handled,
    output reg  [11:0]  o_mem_addr,
    output reg          o_mem_rd,
    output reg          o_mem_wr,
    output reg  [7:0]   o_mem_wdata,
    output reg  [7:0]   o_working,
    output reg  [7:0]   o_bank_select
);

    // ****************************************
    // States, one per instruction cycle
    // ****************************************
    localparam [1:0] ST_FIRST = 2'b00;
    localparam [1:0] ST_MOVE2 = 2'b01;
    localparam [1:0] ST_MOVE3 = 2'b10;

    wire        q1;
    wire        q2;
    wire        q3;
    wire        q4;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [15:0] ir_r;
    reg  [11:0] src_r;
    reg  [11:0] dst_r;
    reg  [7:0]  data_r;

    dmx_quarter u_quarter
    (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .o_q1      (q1),
        .o_q2      (q2),
        .o_q3      (q3),
        .o_q4      (q4)
    );

    // ****************************************
    // Decode
    // ****************************************
    // Live word decodes in Q1, the held copy for the rest of the cycle
    wire [15:0] word     = q1 ? i_instr : ir_r;
    wire [7:0]  lit      = word[`DMX_LIT_HI:0];
    wire        in_first = (state_r == ST_FIRST);

    wire is_move1 = in_first
                    && (word[`DMX_NIB_HI:`DMX_NIB_LO] == `DMX_OP_MOVE_FIRST);
    wire is_stray = in_first
                    && (word[`DMX_NIB_HI:`DMX_NIB_LO] == `DMX_OP_MOVE_SECOND);
    wire is_lbank = in_first
                    && (word[`DMX_BYTE_HI:`DMX_BYTE_LO] == `DMX_OP_LOAD_BANK);
    wire is_lwork = in_first
                    && (word[`DMX_BYTE_HI:`DMX_BYTE_LO] == `DMX_OP_LOAD_WORK);
    wire is_store = in_first
                    && (word[`DMX_OP7_HI:`DMX_OP7_LO] == `DMX_OP_STORE_WORK);

    // Access bank: low half maps to the bottom page, high half to the top page
    wire [3:0] access_bank = (lit < ACCESS_SPLIT) ? `DMX_ACCESS_LO_BANK
                                                  : `DMX_ACCESS_HI_BANK;
    wire [3:0] bank        = word[`DMX_ABIT] ? o_bank_select[`DMX_BANK_HI:0]
                                             : access_bank;
    wire [11:0] file_addr  = {bank, lit};

    // Move-final is the cycle whose Q4 carries the destination write
    // Hold is read in Q3 and again in Q4, so it must stand across both
    wire move_final = ((state_r == ST_MOVE2) && !i_hold) || (state_r == ST_MOVE3);
    // Protected destinations are not filtered; keeping them out is up to software

    // ****************************************
    // Cycle sequencing
    // ****************************************
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_FIRST:
                if (is_move1)
                    state_nxt = ST_MOVE2;
            ST_MOVE2:
                // A hold stretches the move to a third cycle
                state_nxt = i_hold ? ST_MOVE3 : ST_FIRST;
            ST_MOVE3:
                state_nxt = ST_FIRST;
            default:
                state_nxt = ST_FIRST;
        endcase
    end

    always @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_r <= ST_FIRST;
            ir_r    <= {2{`DMX_BYTE_RST}};
            src_r   <= `DMX_ADDR_RST;
            dst_r   <= `DMX_ADDR_RST;
        end
        else
        begin
            if (q1)
                ir_r <= i_instr;
            if (q1 && is_move1)
                src_r <= i_instr[`DMX_ADDR_HI:0];
            // Second word supplies the full destination, bank ignored
            if (q1 && (state_r == ST_MOVE2))
                dst_r <= i_instr[`DMX_ADDR_HI:0];
            if (q4)
                state_r <= state_nxt;
        end
    end

    // ****************************************
    // Data path and memory strobes
    // ****************************************
    // Strobes are set one phase early so they stand through the named quarter
    always @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_mem_addr    <= `DMX_ADDR_RST;
            o_mem_rd      <= 1'b0;
            o_mem_wr      <= 1'b0;
            o_mem_wdata   <= `DMX_BYTE_RST;
            data_r        <= `DMX_BYTE_RST;
        end
        else
        begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            // Source read stands in Q2 of the first cycle
            if (q1 && is_move1 && (i_instr[`DMX_ADDR_HI:0] != WORK_ADDR))
            begin
                o_mem_addr <= i_instr[`DMX_ADDR_HI:0];
                o_mem_rd   <= 1'b1;
            end
            // Working register is mapped, so it is served internally
            if (q2 && (state_r == ST_FIRST) && is_move1)
                data_r <= (src_r == WORK_ADDR) ? o_working : i_mem_rdata;
            if (q3 && move_final && (dst_r != WORK_ADDR))
            begin
                o_mem_addr  <= dst_r;
                o_mem_wdata <= data_r;
                o_mem_wr    <= 1'b1;
            end
            if (q3 && is_store && (file_addr != WORK_ADDR))
            begin
                o_mem_addr  <= file_addr;
                o_mem_wdata <= o_working;
                o_mem_wr    <= 1'b1;
            end
        end
    end

    // ****************************************
    // Core registers
    // ****************************************
    // One writer per register, so a move into W and a literal load never race
    always @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_working     <= `DMX_BYTE_RST;
            o_bank_select <= `DMX_BYTE_RST;
        end
        else
        begin
            if (q4 && move_final && (dst_r == WORK_ADDR))
                o_working <= data_r;
            else if (q4 && is_lwork)
                o_working <= lit;
            if (q4 && is_lbank)
                o_bank_select <= lit;
        end
    end

    // ****************************************
    // Instruction handshake
    // ****************************************
    // No flag outputs exist: none of these instructions touch status
    // Done marks the Q4 of an instruction's final cycle
    assign o_word_taken  = q1;
    assign o_done        = q4 && (state_nxt == ST_FIRST);
    assign o_not_handled = q1 && in_first && !(is_move1 || is_stray || is_lbank
                                               || is_lwork || is_store);

endmodule

`default_nettype wire

// [tb/dmx_exec_props.sv]
// Port-level checker for the data-move execution block
`timescale 1ns/1ps
`default_nettype none
module dmx_exec_props
#(
    parameter [11:0] WORK_ADDR    = 12'hff0,
    parameter [7:0]  ACCESS_SPLIT = 8'h80
)
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic [15:0] i_instr,
    input wire logic        i_hold,
    input wire logic        o_word_taken,
    input wire logic        o_done,
    input wire logic [11:0] o_mem_addr,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_wr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic [7:0]  o_working,
    input wire logic [7:0]  o_bank_select
);
    logic [1:0]  q_r;
    logic [15:0] ins_r;
    logic        fst_r;
    logic        sec_r;
    logic        hld_r;
    logic [11:0] dst_r;
    logic [11:0] st_a;
    // Word latched per cycle; fst_r tells an opening word from a continuation word
    assign st_a = {ins_r[8] ? o_bank_select[3:0] : ((ins_r[7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hf),
                   ins_r[7:0]};
    always @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q_r   <= 2'h0;
            ins_r <= 16'h0000;
            fst_r <= 1'b0;
            sec_r <= 1'b0;
            hld_r <= 1'b0;
            dst_r <= 12'h000;
        end
        else
        begin
            q_r <= q_r + 2'h1;
            if (o_word_taken)
            begin
                ins_r <= i_instr;
                fst_r <= !sec_r && !hld_r;
                sec_r <= !sec_r && !hld_r && (i_instr[15:12] == 4'hc);
                if (sec_r)
                    dst_r <= i_instr[11:0];
            end
            // A held second cycle makes the next word a continuation as well
            if (q_r == 2'h3)
                hld_r <= !fst_r && !hld_r && i_hold;
        end
    end
    default clocking dcb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_taken_q1: assert property (o_word_taken == (q_r == 2'h0))
        else $error("word not taken in first quarter");
    a_done_q4: assert property (o_done |-> q_r == 2'h3)
        else $error("done outside last quarter");
    a_src_rd: assert property (o_mem_rd |-> q_r == 2'h1 && ins_r[15:12] == 4'hc &&
        o_mem_addr == ins_r[11:0] && o_mem_addr != WORK_ADDR) else $error("bad source read");
    a_wr_done: assert property (o_mem_wr |-> o_done && o_mem_addr != WORK_ADDR)
        else $error("write off final quarter");
    a_move_wr: assert property (q_r == 2'h3 && !fst_r && (hld_r || !i_hold) &&
        dst_r != WORK_ADDR |-> o_mem_wr && o_mem_addr == dst_r)
        else $error("move write missing");
    a_hold_wait: assert property (q_r == 2'h3 && !fst_r && !hld_r && i_hold
        |-> !o_mem_wr && !o_done) else $error("held move finished early");
    a_store_wr: assert property (q_r == 2'h3 && fst_r && ins_r[15:9] == 7'h37 &&
        st_a != WORK_ADDR |-> o_mem_wr && o_mem_addr == st_a && o_mem_wdata == o_working)
        else $error("store write wrong");
    a_lit_work: assert property (q_r == 2'h3 && fst_r && ins_r[15:8] == 8'h0e
        |=> o_working == ins_r[7:0]) else $error("working literal not loaded");
    a_lit_bank: assert property (q_r == 2'h3 && fst_r && ins_r[15:8] == 8'h01
        |=> o_bank_select == ins_r[7:0]) else $error("bank literal not loaded");
    a_stray_nop: assert property (q_r == 2'h3 && fst_r && ins_r[15:12] == 4'hf
        |-> !o_mem_wr ##1 ($stable(o_working) && $stable(o_bank_select)))
        else $error("stray continuation word acted");
endmodule
bind dmx_exec dmx_exec_props #(.WORK_ADDR(WORK_ADDR), .ACCESS_SPLIT(ACCESS_SPLIT)) u_props
(
    .i_ref_clk, .i_reset, .i_instr, .i_hold, .o_word_taken, .o_done, .o_mem_addr,
    .o_mem_rd, .o_mem_wr, .o_mem_wdata, .o_working, .o_bank_select
);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the data-move execution block
`timescale 1ns/1ps
`default_nettype none
`include "dmx_defines.vh"
module testbench;
    logic        i_ref_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic [15:0] i_instr   = 16'h0000;
    logic        i_hold    = 1'b0;
    wire  [7:0]  i_mem_rdata;
    wire         o_word_taken, o_done, o_not_handled, o_mem_rd, o_mem_wr;
    wire  [11:0] o_mem_addr;
    wire  [7:0]  o_mem_wdata, o_working, o_bank_select;
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    int          wr_n      = 0;
    logic [11:0] wr_a;
    logic [7:0]  wr_d;
    dmx_exec u_dmx_exec
    (
        .i_ref_clk, .i_reset, .i_instr, .i_hold, .i_mem_rdata, .o_word_taken, .o_done,
        .o_not_handled, .o_mem_addr, .o_mem_rd, .o_mem_wr, .o_mem_wdata, .o_working,
        .o_bank_select
    );
    function automatic logic [7:0] mem_at(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'hc3;
    endfunction
    // Outside a read the bus shows the inverse, so a stale capture cannot match
    assign i_mem_rdata = o_mem_rd ? mem_at(o_mem_addr) : ~mem_at(o_mem_addr);
    always #2.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (o_mem_wr)
        begin
            wr_n <= wr_n + 1;
            wr_a <= o_mem_addr;
            wr_d <= o_mem_wdata;
        end
        if (cyc == 2000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // dn[1] skips the done check, dn[0] is the expected done level
    task automatic issue(input logic [15:0] w, input logic [1:0] dn, input logic nh);
        i_instr <= w;
        @(negedge i_ref_clk);
        chk("taken", 1'b1, o_word_taken);
        chk("unhandled", nh, o_not_handled);
        repeat (3) @(negedge i_ref_clk);
        if (!dn[1])
            chk("done", dn[0], o_done);
        @(posedge i_ref_clk);
    endtask
    // A stray continuation word is a one-cycle no-operation, so it still ends in Q4
    task automatic idle;
        issue(16'hf000, 2'b01, 1'b0);
    endtask
    task automatic t_lit;
        issue(16'h0e5a, 2'b01, 1'b0);
        issue(16'h0105, 2'b01, 1'b0);
        chk("working", 8'h5a, o_working);
        issue(16'h0d00, 2'b10, 1'b1);
        chk("bank", 8'h05, o_bank_select);
        chk("working kept", 8'h5a, o_working);
        $display("t_lit done");
    endtask
    task automatic t_store;
        logic [15:0] w [4] = '{16'h6f20, 16'h6e20, 16'h6e90, 16'h6fff};
        logic [11:0] a [4] = '{12'h520, 12'h020, 12'hf90, 12'h5ff};
        for (int k = 0; k < 4; k++)
        begin
            issue(w[k], 2'b01, 1'b0);
            idle();
            chk("store addr", a[k], wr_a);
            chk("store data", 8'h5a, wr_d);
        end
        $display("t_store done");
    endtask
    task automatic t_move;
        // Plain data bytes only: no interrupt settings are ever touched
        logic [11:0] s [3] = '{12'h123, 12'h000, 12'hfff};
        // Destinations are plain data, never program counter or stack top bytes
        logic [11:0] d [3] = '{12'h456, 12'hfff, 12'h000};
        int n;
        n = wr_n;
        for (int k = 0; k < 3; k++)
        begin
            issue({4'hc, s[k]}, 2'b00, 1'b0);
            issue({4'hf, d[k]}, 2'b01, 1'b0);
            idle();
            chk("move addr", d[k], wr_a);
            chk("move data", mem_at(s[k]), wr_d);
        end
        chk("move writes", 12'(n + 3), 12'(wr_n));
        issue({4'hc, `DMX_WORK_ADDR}, 2'b00, 1'b0);
        issue(16'hf7ab, 2'b01, 1'b0);
        idle();
        chk("w src data", 8'h5a, wr_d);
        issue(16'hc123, 2'b00, 1'b0);
        issue({4'hf, `DMX_WORK_ADDR}, 2'b01, 1'b0);
        idle();
        chk("w dst", mem_at(12'h123), o_working);
        chk("w dst no wr", 12'h7ab, wr_a);
        $display("t_move done");
    endtask
    task automatic t_hold;
        int n;
        n = wr_n;
        issue(16'hc456, 2'b00, 1'b0);
        i_hold <= 1'b1;
        issue(16'hf321, 2'b00, 1'b0);
        i_hold <= 1'b0;
        issue(16'hf000, 2'b01, 1'b0);
        issue(16'hf789, 2'b10, 1'b0);
        idle();
        chk("writes", 12'(n + 1), 12'(wr_n));
        chk("held addr", 12'h321, wr_a);
        chk("held data", mem_at(12'h456), wr_d);
        $display("t_hold done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_lit();
        t_store();
        t_move();
        t_hold();
        give_verdict();
    end
endmodule
`default_nettype wire
